// *** core/vpiu_pkg.sv ***
/*
  constants, enums and carrier structs of the vectored priority
  interrupt unit. assumes one 50 MHz system clock, an APB master
  for the registers and a cpu core that acknowledges requests.
*/
package vpiu_pkg;
    localparam int unsigned NSLOT     = 32;
    localparam int unsigned NPIN      = 18;
    localparam int unsigned NSGL      = 14;
    localparam int unsigned P_D_LSB   = 8;
    localparam int unsigned P_CMP_LSB = 12;
    localparam logic [11:0] OFS_PEND  = 12'h000;
    localparam logic [11:0] OFS_LVLA  = 12'h004;
    localparam logic [11:0] OFS_LVLB  = 12'h008;
    localparam logic [11:0] OFS_CTRL  = 12'h00c;
    localparam logic [11:0] OFS_EDGE  = 12'h010;
    localparam logic [11:0] OFS_STAT  = 12'h014;
    localparam int unsigned CTRL_GIE  = 0;
    localparam int unsigned CTRL_WDIE = 1;
    localparam logic [31:0] SLOT_USED = 32'hf3ff_309f;
    localparam logic [13:0] EDGE_RST  = 14'h0000;
    localparam logic [1:0]  LVL_OFF   = 2'h0;
    localparam logic [15:0] VEC_RESET = 16'h0002;
    localparam logic [15:0] VEC_WDOG  = 16'h0004;
    localparam logic [15:0] VEC_CLKF  = 16'h0048;
    localparam logic [15:0] VEC_ILL   = 16'h0006;
    localparam logic [15:0] VEC_BASE  = 16'h0008;
    localparam int unsigned S_T2  = 0;
    localparam int unsigned S_T1  = 1;
    localparam int unsigned S_T0  = 2;
    localparam int unsigned S_URX = 3;
    localparam int unsigned S_UTX = 4;
    localparam int unsigned S_I2C = 7;
    localparam int unsigned S_ADC = 12;
    localparam int unsigned S_SPI = 13;
    localparam int unsigned S_A7  = 16;
    localparam int unsigned S_A6  = 17;
    localparam int unsigned S_A5  = 18;
    localparam int unsigned S_A0  = 23;
    localparam int unsigned S_TA  = 24;
    localparam int unsigned S_MCT = 25;
    localparam int unsigned S_C0  = 31;

    typedef struct packed {
        logic t2, t1, t0, urx, utx, i2c, adc, spi, low_supply_detector, ta, mct;
    } vpiu_periph_t;
    typedef struct packed {
        logic [3:0] port_c;
        logic [1:0] cmp;
        logic [4:1] port_d;
        logic [7:0] port_a;
    } vpiu_pins_t;
    typedef struct packed {
        logic        valid;
        logic        trap;
        logic [15:0] vec;
    } vpiu_req_t;
    typedef logic [NSLOT-1:0][1:0] vpiu_lvl_t;
    typedef enum logic [2:0] {R_NONE, R_PEND, R_LVLA, R_LVLB, R_CTRL, R_EDGE, R_STAT} vpiu_reg_t;
    typedef enum logic [2:0] {SRC_NONE, SRC_RST, SRC_WDOG, SRC_CLKF, SRC_ILL, SRC_IRQ} vpiu_src_t;
    typedef enum logic [1:0] {F_IDLE, F_HI, F_LO, F_LAST} vpiu_fst_t;
endpackage : vpiu_pkg

// *** core/vpiu_core.sv ***
/*
  vectored priority interrupt unit: pending store, level arbiter,
  trap ranking, vector fetch and APB register slave.
  assumes peripheral, trap and cpu strobes are one-cycle pulses on
  sys_clk_in; pins arrive asynchronous; program memory answers one
  cycle after a read strobe.
*/
// The implementer's own choices: the APB register port and the placing of the registers.
module vpiu_core
    import vpiu_pkg::*;
#(
    parameter int unsigned PM_ADDR_W = 16
)(
    input  wire logic                 sys_clk_in,
    input  wire logic                 rst_in,
    input  wire logic                 psel_in,
    input  wire logic                 penable_in,
    input  wire logic                 pwrite_in,
    input  wire logic [11:0]          paddr_in,
    input  wire logic [31:0]          pwdata_in,
    output logic      [31:0]          prdata_out,
    output logic                      pready_out,
    output logic                      pslverr_out,
    input  wire vpiu_periph_t         periph_in,
    input  wire vpiu_pins_t           pins_in,
    input  wire logic                 watchdog_counter_evt_in,
    input  wire logic                 clk_fail_in,
    input  wire logic                 ill_instr_in,
    input  wire logic                 enable_requests_instruction_in,
    input  wire logic                 disable_requests_instruction_in,
    input  wire logic                 return_from_service_instruction_in,
    input  wire logic                 trap_instr_in,
    input  wire logic                 smr_in,
    input  wire logic                 ack_in,
    output vpiu_req_t                 req_out,
    output logic                      gie_out,
    output logic                      pm_rd_out,
    output logic      [PM_ADDR_W-1:0] pm_addr_out,
    input  wire logic [7:0]           pm_data_in,
    output logic      [15:0]          isr_addr_out,
    output logic                      isr_valid_out
);
    if (PM_ADDR_W < 7 || PM_ADDR_W > 16) begin : g_chk
        $error("program memory address width out of range");
    end

    function automatic vpiu_reg_t dec(input logic [11:0] a);
        case (a)
            OFS_PEND: dec = R_PEND;
            OFS_LVLA: dec = R_LVLA;
            OFS_LVLB: dec = R_LVLB;
            OFS_CTRL: dec = R_CTRL;
            OFS_EDGE: dec = R_EDGE;
            OFS_STAT: dec = R_STAT;
            default:  dec = R_NONE;
        endcase
    endfunction : dec

    function automatic logic [6:0] pick(input logic [NSLOT-1:0] c, input vpiu_lvl_t l);
        logic [1:0] bl;
        logic [4:0] bs;
        bl = LVL_OFF;
        bs = '0;
        for (int i = NSLOT - 1; i >= 0; i--)
        begin
            if (c[i] && l[i] != LVL_OFF && l[i] >= bl)
            begin
                bl = l[i];
                bs = 5'(i);
            end
        end
        pick = {bl, bs};
    endfunction : pick

    logic       acc, wr, ack_take, best_found;
    vpiu_reg_t  rsel;
    logic [1:0] best_lvl, max_lvl;
    logic [4:0] best_slot;
    // apb decode, zero wait states
    assign acc         = psel_in && penable_in;
    assign wr          = acc && pwrite_in;
    assign rsel        = dec(paddr_in);
    assign pready_out  = 1'b1;
    assign pslverr_out = acc && (rsel == R_NONE);

    // pin synchronisers and edge detect
    vpiu_pins_t       s1_r, s2_r, prv_r;
    logic [NPIN-1:0]  rise, fall;
    logic [NSGL-1:0]  sgl;
    logic [3:0]       dual;
    logic [NSGL-1:0]  edge_r, edge_nxt;
    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            s1_r  <= '0;
            s2_r  <= '0;
            prv_r <= '0;
        end
        else
        begin
            s1_r  <= pins_in;
            s2_r  <= s1_r;
            prv_r <= s2_r;
        end
    end
    assign rise = s2_r & ~prv_r;
    assign fall = ~s2_r & prv_r;
    assign sgl  = (rise[NSGL-1:0] & edge_r) | (fall[NSGL-1:0] & ~edge_r);
    assign dual = rise[NPIN-1:NSGL] | fall[NPIN-1:NSGL];

    // request sources onto vector slots
    logic [NSLOT-1:0] set_vec;
    always_comb
    begin
        set_vec         = '0;
        set_vec[S_T2]   = periph_in.t2;
        set_vec[S_T1]   = periph_in.t1;
        set_vec[S_T0]   = periph_in.t0;
        set_vec[S_URX]  = periph_in.urx;
        set_vec[S_UTX]  = periph_in.utx;
        set_vec[S_I2C]  = periph_in.i2c;
        set_vec[S_ADC]  = periph_in.adc;
        set_vec[S_SPI]  = periph_in.spi;
        set_vec[S_A7]   = sgl[7] | periph_in.low_supply_detector;
        set_vec[S_A6]   = sgl[6] | sgl[P_CMP_LSB];
        set_vec[S_A5]   = sgl[5] | sgl[P_CMP_LSB+1];
        for (int i = 1; i <= 4; i++)
        begin
            set_vec[S_A0-i] = sgl[i] | sgl[P_D_LSB+i-1];
        end
        set_vec[S_A0]   = sgl[0];
        set_vec[S_TA]   = periph_in.ta;
        set_vec[S_MCT]  = periph_in.mct;
        for (int i = 0; i < 4; i++)
        begin
            set_vec[S_C0-i] = dual[i];
        end
    end

    // configuration and global enable
    vpiu_lvl_t lvl_r, lvl_nxt;
    logic      gie_r, gie_nxt, wdie_r, wdie_nxt;
    always_comb
    begin
        lvl_nxt  = lvl_r;
        edge_nxt = edge_r;
        wdie_nxt = wdie_r;
        gie_nxt  = gie_r;
        if (wr && rsel == R_LVLA)
            lvl_nxt[15:0] = pwdata_in;
        if (wr && rsel == R_LVLB)
            lvl_nxt[31:16] = pwdata_in;
        if (wr && rsel == R_EDGE)
            edge_nxt = pwdata_in[NSGL-1:0];
        if (wr && rsel == R_CTRL)
        begin
            wdie_nxt = pwdata_in[CTRL_WDIE];
            gie_nxt  = pwdata_in[CTRL_GIE];
        end
        if (enable_requests_instruction_in || return_from_service_instruction_in)
            gie_nxt = 1'b1;
        if (smr_in || disable_requests_instruction_in || trap_instr_in || ack_take)
            gie_nxt = 1'b0;
    end
    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            lvl_r  <= '0;
            edge_r <= EDGE_RST;
            wdie_r <= 1'b0;
            gie_r  <= 1'b0;
        end
        else
        begin
            lvl_r  <= lvl_nxt;
            edge_r <= edge_nxt;
            wdie_r <= wdie_nxt;
            gie_r  <= gie_nxt;
        end
    end
    assign gie_out = gie_r;

    // pending store; hardware set wins over any clear
    logic [NSLOT-1:0] pend_r, pend_nxt;
    logic             rsp_r, rsp_nxt, wdp_r, wdp_nxt, cfp_r, cfp_nxt, ilp_r, ilp_nxt;
    vpiu_src_t        src_r, src_nxt;
    logic [4:0]       slot_r, slot_nxt;
    always_comb
    begin
        pend_nxt = pend_r;
        rsp_nxt  = rsp_r;
        wdp_nxt  = wdp_r;
        cfp_nxt  = cfp_r;
        ilp_nxt  = ilp_r;
        if (ack_take)
        begin
            case (src_r)
                SRC_IRQ:  pend_nxt[slot_r] = 1'b0;
                SRC_RST:  rsp_nxt = 1'b0;
                SRC_WDOG: wdp_nxt = 1'b0;
                SRC_CLKF: cfp_nxt = 1'b0;
                SRC_ILL:  ilp_nxt = 1'b0;
                default:  rsp_nxt = rsp_r;
            endcase
        end
        // software raise beats an ack in the same cycle
        if (wr && rsel == R_PEND)
            pend_nxt = pwdata_in;
        pend_nxt = (pend_nxt | set_vec) & SLOT_USED;
        if (watchdog_counter_evt_in && wdie_r)
            wdp_nxt = 1'b1;
        if (clk_fail_in)
            cfp_nxt = 1'b1;
        if (ill_instr_in)
            ilp_nxt = 1'b1;
    end
    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            pend_r <= '0;
            rsp_r  <= 1'b1;
            wdp_r  <= 1'b0;
            cfp_r  <= 1'b0;
            ilp_r  <= 1'b0;
        end
        else
        begin
            pend_r <= pend_nxt;
            rsp_r  <= rsp_nxt;
            wdp_r  <= wdp_nxt;
            cfp_r  <= cfp_nxt;
            ilp_r  <= ilp_nxt;
        end
    end

    // arbitration among enabled levels
    assign {best_lvl, best_slot} = pick(pend_r, lvl_r);
    assign best_found = (best_lvl != LVL_OFF);

    // presenter and two-byte vector fetch
    vpiu_req_t          req_r, req_nxt;
    vpiu_fst_t          fst_r, fst_nxt;
    logic [15:0]        fad_r, fad_nxt, isr_r, isr_nxt;
    logic [7:0]         hi_r, hi_nxt;
    logic               rd_r, rd_nxt, isv_r, isv_nxt;
    logic [PM_ADDR_W-1:0] pma_r, pma_nxt;
    assign ack_take = ack_in && req_r.valid && fst_r == F_IDLE;
    always_comb
    begin
        req_nxt  = '0;
        src_nxt  = SRC_NONE;
        slot_nxt = slot_r;
        fst_nxt  = fst_r;
        fad_nxt  = fad_r;
        hi_nxt   = hi_r;
        rd_nxt   = 1'b0;
        pma_nxt  = pma_r;
        isr_nxt  = isr_r;
        isv_nxt  = 1'b0;
        if (!ack_take && fst_r == F_IDLE)
        begin
            req_nxt.valid = 1'b1;
            req_nxt.trap  = 1'b1;
            if (rsp_r)
            begin
                req_nxt.vec = VEC_RESET;
                src_nxt     = SRC_RST;
            end
            else if (wdp_r && gie_r)
            begin
                req_nxt.vec  = VEC_WDOG;
                req_nxt.trap = 1'b0;
                src_nxt      = SRC_WDOG;
            end
            else if (cfp_r)
            begin
                req_nxt.vec = VEC_CLKF;
                src_nxt     = SRC_CLKF;
            end
            else if (ilp_r)
            begin
                req_nxt.vec = VEC_ILL;
                src_nxt     = SRC_ILL;
            end
            else if (gie_r && best_found)
            begin
                req_nxt.vec  = 16'(VEC_BASE + {10'h000, best_slot, 1'b0});
                req_nxt.trap = 1'b0;
                src_nxt      = SRC_IRQ;
                slot_nxt     = best_slot;
            end
            else
                req_nxt = '0;
        end
        case (fst_r)
            F_IDLE:
            begin
                if (ack_take)
                begin
                    fad_nxt = req_r.vec;
                    rd_nxt  = 1'b1;
                    pma_nxt = PM_ADDR_W'(req_r.vec);
                    fst_nxt = F_HI;
                end
            end
            F_HI:
            begin
                rd_nxt  = 1'b1;
                pma_nxt = PM_ADDR_W'(fad_r | 16'h0001);
                fst_nxt = F_LO;
            end
            F_LO:
            begin
                hi_nxt  = pm_data_in;
                fst_nxt = F_LAST;
            end
            F_LAST:
            begin
                isr_nxt = {hi_r, pm_data_in};
                isv_nxt = 1'b1;
                fst_nxt = F_IDLE;
            end
            default: fst_nxt = F_IDLE;
        endcase
    end
    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            req_r  <= '0;
            src_r  <= SRC_NONE;
            slot_r <= '0;
            fst_r  <= F_IDLE;
            fad_r  <= '0;
            hi_r   <= '0;
            rd_r   <= 1'b0;
            pma_r  <= '0;
            isr_r  <= '0;
            isv_r  <= 1'b0;
        end
        else
        begin
            req_r  <= req_nxt;
            src_r  <= src_nxt;
            slot_r <= slot_nxt;
            fst_r  <= fst_nxt;
            fad_r  <= fad_nxt;
            hi_r   <= hi_nxt;
            rd_r   <= rd_nxt;
            pma_r  <= pma_nxt;
            isr_r  <= isr_nxt;
            isv_r  <= isv_nxt;
        end
    end
    assign req_out       = req_r;
    assign pm_rd_out     = rd_r;
    assign pm_addr_out   = pma_r;
    assign isr_addr_out  = isr_r;
    assign isr_valid_out = isv_r;

    // read data latched in the setup cycle
    logic [31:0] prd_r, prd_nxt;
    always_comb
    begin
        prd_nxt = prd_r;
        if (psel_in && !penable_in && !pwrite_in)
        begin
            case (rsel)
                R_PEND:  prd_nxt = pend_r;
                R_LVLA:  prd_nxt = lvl_r[15:0];
                R_LVLB:  prd_nxt = lvl_r[31:16];
                R_CTRL:  prd_nxt = {30'h0, wdie_r, gie_r};
                R_EDGE:  prd_nxt = {18'h0, edge_r};
                R_STAT:  prd_nxt = {12'h000, fst_r != F_IDLE, gie_r, req_r};
                default: prd_nxt = '0;
            endcase
        end
    end
    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
            prd_r <= '0;
        else
            prd_r <= prd_nxt;
    end
    assign prdata_out = prd_r;

    // checks
    always_comb
    begin
        max_lvl = LVL_OFF;
        for (int i = 0; i < NSLOT; i++)
        begin
            if (pend_r[i] && lvl_r[i] > max_lvl)
                max_lvl = lvl_r[i];
        end
    end
    default clocking dc @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    pend_set_a: assert property ((set_vec & SLOT_USED) != 0 |=>
        (pend_r & $past(set_vec & SLOT_USED)) == $past(set_vec & SLOT_USED))
        else $error("request pulse lost");
    sw_raise_a: assert property (wr && rsel == R_PEND && pwdata_in[S_T0] |=>
        pend_r[S_T0]) else $error("software raise lost");
    gie_clear_a: assert property (ack_take |=> !gie_r)
        else $error("enable not cleared on ack");
    reset_vec_a: assert property (rsp_r && fst_r == F_IDLE && !ack_take |=>
        req_r.valid && req_r.trap && req_r.vec == VEC_RESET) else $error("reset vector wrong");
    wdog_rank_a: assert property (!rsp_r && wdp_r && gie_r && fst_r == F_IDLE && !ack_take
        |=> req_r.vec == VEC_WDOG) else $error("watchdog rank wrong");
    clkf_rank_a: assert property (!rsp_r && !(wdp_r && gie_r) && cfp_r && fst_r == F_IDLE
        && !ack_take |=> req_r.trap && req_r.vec == VEC_CLKF) else $error("clock trap rank");
    ill_rank_a: assert property (!rsp_r && !(wdp_r && gie_r) && !cfp_r && ilp_r
        && fst_r == F_IDLE && !ack_take |=> req_r.vec == VEC_ILL) else $error("illegal trap");
    poll_quiet_a: assert property (!gie_r |=> !(req_r.valid && !req_r.trap))
        else $error("interrupt presented while disabled");
    level_max_a: assert property (best_lvl == max_lvl)
        else $error("lower level won");
    fetch_seq_a: assert property (ack_take |=> rd_r && pma_r == $past(PM_ADDR_W'(req_r.vec))
        ##1 rd_r && pma_r[0] ##2 isv_r && isr_r == {$past(pm_data_in, 2), $past(pm_data_in)})
        else $error("vector fetch order wrong");
endmodule : vpiu_core

// *** test/vpiu_cpu_model.sv ***
/*
  cpu side of the interrupt unit: acknowledges one request each
  time go_in rises and answers vector reads from program memory.
  assumes memory holds the address low byte xor KEY.
*/
module vpiu_cpu_model
    import vpiu_pkg::*;
#(
    parameter logic [7:0] KEY = 8'h3c
)(
    input  wire logic        sys_clk_in,
    input  wire logic        rst_in,
    input  wire logic        go_in,
    input  wire vpiu_req_t   req_in,
    input  wire logic        pm_rd_in,
    input  wire logic [15:0] pm_addr_in,
    output logic             ack_out,
    output logic [7:0]       pm_data_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic taken_r;
    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            ack_out     <= 1'b0;
            taken_r     <= 1'b0;
            pm_data_out <= 8'h00;
        end
        else
        begin
            ack_out <= go_in && !taken_r && req_in.valid;
            taken_r <= go_in && (taken_r || req_in.valid);
            if (pm_rd_in)
                pm_data_out <= pm_addr_in[7:0] ^ KEY;
            else
                pm_data_out <= ~pm_data_out;
        end
    end
endmodule : vpiu_cpu_model

// *** test/vectored_priority_interrupt_unit_tb.sv ***
/*
  self-checking bench of the interrupt unit against a queue-free
  behavioural model of pending bits and levels.
  assumes the cpu model answers vector reads after one cycle.
*/
`define CHK(nm, ex, got) \
    begin \
        compares++; \
        if ((got) !== (ex)) \
        begin \
            num_errors++; \
            $display("mismatch %s expected %h seen %h", nm, ex, got); \
        end \
    end

module vectored_priority_interrupt_unit_tb;
    import vpiu_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] KEY = 8'h3c;
    logic          sys_clk_in, rst_in, psel, penable, pwrite, pready, pslverr, re;
    logic [11:0]   paddr;
    logic [31:0]   pwdata, prdata, rq, lva;
    vpiu_periph_t  periph;
    vpiu_pins_t    pins;
    logic          wdog, clkf, ill, ack, go, gie, pm_rd, isr_valid;
    logic [4:0]    gev;
    logic [15:0]   pm_addr, isr_addr;
    logic [7:0]    pm_data;
    vpiu_req_t     req;
    int            num_errors, compares, s;
    int            lv[32];
    bit [31:0]     pend;

    vpiu_core i_vpiu_core (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .periph_in(periph), .pins_in(pins), .watchdog_counter_evt_in(wdog),
        .clk_fail_in(clkf), .ill_instr_in(ill), .enable_requests_instruction_in(gev[4]),
        .return_from_service_instruction_in(gev[3]), .disable_requests_instruction_in(gev[2]),
        .smr_in(gev[1]), .trap_instr_in(gev[0]), .ack_in(ack), .req_out(req),
        .gie_out(gie), .pm_rd_out(pm_rd), .pm_addr_out(pm_addr), .pm_data_in(pm_data),
        .isr_addr_out(isr_addr), .isr_valid_out(isr_valid));
    vpiu_cpu_model #(.KEY(KEY)) i_vpiu_cpu_model (.sys_clk_in(sys_clk_in),
        .rst_in(rst_in), .go_in(go), .req_in(req), .pm_rd_in(pm_rd),
        .pm_addr_in(pm_addr), .ack_out(ack), .pm_data_out(pm_data));

    task automatic test_done();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : test_done

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge sys_clk_in);
        penable <= 1'b1;
        do
        begin
            @(posedge sys_clk_in);
        end
        while (pready !== 1'b1);
        rq = prdata;
        re = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk_in);
    endtask : apb

    task automatic waitfor(input int k);
        do
        begin
            @(negedge sys_clk_in);
        end
        while (((k == 0) ? req.valid : isr_valid) !== 1'b1);
        @(posedge sys_clk_in);
    endtask : waitfor

    task automatic gie_step(input logic [4:0] p, input logic ex);
        gev <= p;
        @(posedge sys_clk_in);
        gev <= 5'h00;
        @(posedge sys_clk_in);
        `CHK("gie", ex, gie)
    endtask : gie_step

    task automatic serve(input logic [15:0] ev, input logic et);
        waitfor(0);
        `CHK("vector", ev, req.vec)
        if (et !== 1'bx)
            `CHK("trap", et, req.trap)
        go <= 1'b1;
        waitfor(1);
        `CHK("isr", {ev[7:0] ^ KEY, (ev[7:0] | 8'h01) ^ KEY}, isr_addr)
        go <= 1'b0;
        `CHK("gie", 1'b0, gie)
    endtask : serve

    function automatic int best();
        for (int l = 3; l > 0; l--)
            for (int k = 0; k < 32; k++)
                if (pend[k] && lv[k] == l)
                    return k;
        return -1;
    endfunction : best

    task automatic drain();
        while (best() >= 0)
        begin
            s = best();
            gev <= 5'h10;
            @(posedge sys_clk_in);
            gev <= 5'h00;
            @(negedge sys_clk_in);
            `CHK("gie", 1'b1, gie)
            @(posedge sys_clk_in);
            serve(VEC_BASE + 16'(2 * s), 1'b0);
            pend[s] = 1'b0;
        end
        apb(1'b1, OFS_PEND, 32'h0);
        pend = '0;
    endtask : drain

    initial
    begin
        sys_clk_in = 1'b0;
        forever #10 sys_clk_in = ~sys_clk_in;
    end

    initial
    begin
        repeat (20000) @(posedge sys_clk_in);
        num_errors++;
        test_done();
    end

    initial
    begin
        {psel, penable, pwrite, wdog, clkf, ill, go} = '0;
        gev = '0;
        paddr = '0;
        pwdata = '0;
        periph = '0;
        pins = '0;
        pend = '0;
        num_errors = 0;
        compares = 0;
        rst_in = 1'b1;
        void'($urandom(39068));
        repeat (12) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        serve(VEC_RESET, 1'b1);
        foreach (lv[k])
        begin
            lv[k] = 0;
            apb(1'b0, 12'(4 * (k % 6)), 32'h0);
            `CHK("reg", 32'h0, rq)
        end
        apb(1'b0, 12'h018, 32'h0);
        `CHK("slverr", 1'b1, re)
        $display("test reset done");
        apb(1'b1, OFS_LVLA, 32'h5555_5555);
        for (int k = 0; k < 16; k++)
            lv[k] = 1;
        periph <= vpiu_periph_t'(11'h7f8);
        @(posedge sys_clk_in);
        periph <= '0;
        pend = 32'h309f;
        drain();
        $display("test order done");
        repeat (4)
        begin
            for (int k = 0; k < 16; k++)
            begin
                lv[k] = $urandom_range(3, 0);
                lva[2*k+:2] = 2'(lv[k]);
            end
            apb(1'b1, OFS_LVLA, lva);
            pend = $urandom & 32'h309f;
            apb(1'b1, OFS_PEND, pend);
            drain();
        end
        $display("test levels done");
        clkf <= 1'b1;
        ill  <= 1'b1;
        @(posedge sys_clk_in);
        {clkf, ill} <= 2'b00;
        serve(VEC_CLKF, 1'b1);
        serve(VEC_ILL, 1'b1);
        apb(1'b1, OFS_CTRL, 32'h3);
        wdog <= 1'b1;
        @(posedge sys_clk_in);
        wdog <= 1'b0;
        serve(VEC_WDOG, 1'b0);
        $display("test traps done");
        periph <= vpiu_periph_t'(11'h080);
        @(posedge sys_clk_in);
        periph <= '0;
        repeat (4) @(posedge sys_clk_in);
        apb(1'b0, OFS_PEND, 32'h0);
        `CHK("pend", 32'h8, rq)
        `CHK("valid", 1'b0, req.valid)
        apb(1'b1, OFS_PEND, 32'h0);
        apb(1'b0, OFS_PEND, 32'h0);
        `CHK("pend", 32'h0, rq)
        $display("test polling done");
        gie_step(5'h08, 1'b1);
        gie_step(5'h04, 1'b0);
        gie_step(5'h10, 1'b1);
        gie_step(5'h02, 1'b0);
        gie_step(5'h10, 1'b1);
        gie_step(5'h01, 1'b0);
        gie_step(5'h10, 1'b1);
        gie_step(5'h14, 1'b0);
        $display("test enable done");
        apb(1'b1, OFS_EDGE, 32'h1080);
        apb(1'b1, OFS_LVLB, 32'h5555_5555);
        for (int k = 16; k < 32; k++)
            lv[k] = 1;
        pins.port_a[7] <= 1'b1;
        repeat (8) @(posedge sys_clk_in);
        pins.cmp[0] <= 1'b1;
        repeat (8) @(posedge sys_clk_in);
        pins.port_c[0] <= 1'b1;
        repeat (8) @(posedge sys_clk_in);
        apb(1'b0, OFS_PEND, 32'h0);
        `CHK("pins", 32'h8003_0000, rq)
        pend = rq;
        drain();
        pins.port_c[0] <= 1'b0;
        pins.port_a[7] <= 1'b0;
        repeat (8) @(posedge sys_clk_in);
        apb(1'b0, OFS_PEND, 32'h0);
        `CHK("pins", 32'h8000_0000, rq)
        $display("test pins done");
        test_done();
    end
endmodule : vectored_priority_interrupt_unit_tb
